/* File: rtl/nfc_params.svh */
// constants of the nand page and cache read controller
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH
// clock rate and busy-onset delay after the last write strobe
`define NFC_CLK_MHZ    20
`define NFC_T_WB_NS    100
`define NFC_WB_CYC     ((`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000)
// register byte offsets on the bus
`define NFC_A_CTRL     8'h00
`define NFC_A_COL      8'h04
`define NFC_A_ROW      8'h08
`define NFC_A_STAT     8'h0c
`define NFC_A_DATA     8'h10
`define NFC_A_CFG      8'h14
// field positions
`define NFC_F_OP       2:0
`define NFC_F_LEN      14:8
`define NFC_F_COL      11:0
`define NFC_F_ROW      15:0
`define NFC_F_ERRCLR   2
`define NFC_F_WPN      0
// nand opcodes
`define NFC_C_READ     8'h00
`define NFC_C_PAGE     8'h30
`define NFC_C_CACHE    8'h31
`define NFC_C_LAST     8'h3f
`define NFC_C_STATUS   8'h70
`define NFC_C_RESET    8'hff
`define NFC_C_COL      8'h05
`define NFC_C_COLGO    8'he0
// page and buffer sizes
`define NFC_PAGE_BYTES 12'h840
`define NFC_BUF_DEPTH  7'h40
`define NFC_BUF_AW     6
`endif

/* File: rtl/nfc_pkg.sv */
// types shared by the nand read controller files
package nfc_pkg;
	// operations software may start through the control register
	typedef enum logic [2:0] {
		OP_PAGE, OP_SEQC, OP_RANDC, OP_LASTC,
		OP_COL, OP_STAT, OP_RST, OP_DATA
	} nfc_op_e;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD1, ST_ADDR, ST_CMD2, ST_TWB, ST_BUSY, ST_READ
	} nfc_st_e;
	// nand pins driven by the controller
	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic [7:0] io_o;
		logic       io_oe;
	} nfc_pins_s;
	// command shape of one operation
	typedef struct packed {
		logic [7:0] c1;
		logic [2:0] naddr;
		logic       has_c2;
		logic [7:0] c2;
		logic       wait_rb;
	} nfc_desc_s;
endpackage

/* File: rtl/nfc_buf.sv */
// byte buffer holding data strobed out of the nand
`timescale 1ns/1ns
`include "nfc_params.svh"
module nfc_buf
	import nfc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   we,
	input  wire logic [`NFC_BUF_AW-1:0] waddr,
	input  wire logic [7:0]             wdata,
	input  wire logic [`NFC_BUF_AW-1:0] raddr,
	output logic      [7:0]             rdata
);
	logic [7:0] mem [`NFC_BUF_DEPTH]; // storage array

	// write port, one byte per read strobe
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port, read every cycle
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule

/* File: rtl/nfc_ctrl.sv */
// host controller driving a nand page and cache read over its pins
`timescale 1ns/1ns
`include "nfc_params.svh"
module nfc_ctrl
	import nfc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  nand_io_i,
	input  wire logic        ready_busy_n,
	output nfc_pins_s        pins
);
	logic       ap_ok;        // accepted address phase
	logic       wr_q;         // write data phase pending
	logic [7:0] wa_q;         // address of pending write
	logic [6:0] len_q;        // last requested read length
	nfc_op_e    op_q;         // last requested operation
	logic [11:0] col_q;       // column register
	logic [15:0] row_q;       // row register
	logic       wp_n_q;       // write protect level
	logic       err_q;        // sticky refused-request flag
	logic [7:0] stat_q;       // last status byte read
	logic       pg_q;         // a page is loaded
	logic       cs_q;         // cache session open
	logic [11:0] pos_q;       // device column pointer
	nfc_st_e    st_q, st_d;   // sequencer state
	logic       ph_q, ph_d;   // strobe phase: 0 low, 1 high
	logic [6:0] cnt_q, cnt_d; // address index, busy-onset wait count or bytes left
	nfc_op_e    dop_q;        // operation being run
	nfc_desc_s  desc_q, dsel; // command shape
	logic [`NFC_BUF_AW-1:0] wp_q, rp_q, rp_d; // buffer pointers
	logic [6:0] fill_q;       // bytes in buffer
	logic [7:0] buf_q;        // buffer read data
	logic       req, go, refuse, allow;
	nfc_op_e    op_w;         // operation being requested
	logic [11:0] lenc, rem, nb12; // read length clipping
	logic       cache_op, rd_cap, data_rd;
	logic [31:0] rmux;
	nfc_pins_s  pins_d;

	// opcode shape of each operation
	function automatic nfc_desc_s nfc_desc(nfc_op_e op, logic pg);
		nfc_desc_s d;
		d = '{c1: `NFC_C_READ, naddr: 3'h0, has_c2: 1'b0,
			c2: `NFC_C_READ, wait_rb: 1'b1};
		unique case (op)
			OP_PAGE: begin
				d.naddr = 3'h4;
				d.has_c2 = 1'b1;
				d.c2 = `NFC_C_PAGE;
			end
			OP_SEQC: d.c1 = `NFC_C_CACHE;
			OP_RANDC: begin
				d.naddr = 3'h4;
				d.has_c2 = 1'b1;
				d.c2 = `NFC_C_CACHE;
			end
			OP_LASTC: d.c1 = `NFC_C_LAST;
			OP_COL: begin
				d.c1 = `NFC_C_COL;
				d.naddr = 3'h2;
				d.has_c2 = 1'b1;
				d.c2 = `NFC_C_COLGO;
				d.wait_rb = 1'b0;
			end
			OP_STAT: begin
				d.c1 = `NFC_C_STATUS;
				d.has_c2 = pg;
				d.wait_rb = 1'b0;
			end
			OP_RST: d.c1 = `NFC_C_RESET;
			OP_DATA: d.wait_rb = 1'b0;
		endcase
		return d;
	endfunction

	// address byte for each address cycle
	function automatic logic [7:0] abyte(logic [6:0] i, logic [11:0] c,
		logic [15:0] r);
		unique case (i[1:0])
			2'h0: return c[7:0];
			2'h1: return {4'h0, c[11:8]};
			2'h2: return r[7:0];
			2'h3: return r[15:8];
		endcase
	endfunction

	// bus request decode
	assign ap_ok   = hsel & hready & htrans[1];
	assign data_rd = ap_ok & ~hwrite & (haddr[7:0] == `NFC_A_DATA);
	assign req     = wr_q & (wa_q == `NFC_A_CTRL);
	assign op_w    = nfc_op_e'(hwdata[`NFC_F_OP]);
	assign cache_op = (op_w == OP_SEQC) | (op_w == OP_RANDC)
		| (op_w == OP_LASTC);

	// read length clipped to buffer size and to the page end
	always_comb begin
		lenc = {5'h00, hwdata[`NFC_F_LEN]};
		if (lenc > {5'h00, `NFC_BUF_DEPTH}) begin
			lenc = {5'h00, `NFC_BUF_DEPTH};
		end
		rem  = `NFC_PAGE_BYTES - pos_q;
		nb12 = (lenc < rem) ? lenc : rem;
	end

	// acceptance of a new operation
	always_comb begin
		allow = (st_q == ST_IDLE);
		if (!ready_busy_n && op_w != OP_STAT && op_w != OP_RST) begin
			allow = 1'b0;
		end
		if (cache_op && !cs_q) begin
			allow = 1'b0;
		end
		if ((op_w == OP_COL || op_w == OP_DATA) && !pg_q) begin
			allow = 1'b0;
		end
		if ((op_w == OP_COL || op_w == OP_PAGE)
			&& col_q >= `NFC_PAGE_BYTES) begin
			allow = 1'b0;
		end
		if (op_w == OP_DATA && nb12 == 12'h000) begin
			allow = 1'b0;
		end
	end
	assign go     = req & allow;
	assign refuse = req & ~allow;
	assign dsel   = go ? nfc_desc(op_w, pg_q) : desc_q;

	// bus data phase tracking and fixed slave answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_q <= ap_ok & hwrite;
			wa_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			col_q <= 12'h000;
			row_q <= 16'h0000;
			wp_n_q <= 1'b0;
			len_q <= 7'h00;
			op_q <= OP_PAGE;
		end else if (wr_q) begin
			unique case (wa_q)
				`NFC_A_COL: col_q <= hwdata[`NFC_F_COL];
				`NFC_A_ROW: row_q <= hwdata[`NFC_F_ROW];
				`NFC_A_CFG: wp_n_q <= hwdata[`NFC_F_WPN];
				`NFC_A_CTRL: begin
					len_q <= hwdata[`NFC_F_LEN];
					op_q <= op_w;
				end
				default: ;
			endcase
		end
	end

	// refused-request flag, a new refusal wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_q <= 1'b0;
		end else begin
			err_q <= refuse | (err_q & ~(wr_q & (wa_q == `NFC_A_STAT)
				& hwdata[`NFC_F_ERRCLR]));
		end
	end

	// page and cache session tracking, column pointer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pg_q <= 1'b0;
			cs_q <= 1'b0;
			pos_q <= 12'h000;
		end else if (go) begin
			unique case (op_w)
				OP_PAGE: begin
					pg_q <= 1'b1;
					cs_q <= 1'b1;
					pos_q <= col_q;
				end
				OP_SEQC, OP_RANDC: pos_q <= 12'h000;
				OP_LASTC: begin
					cs_q <= 1'b0;
					pos_q <= 12'h000;
				end
				OP_COL: pos_q <= col_q;
				OP_RST: begin
					pg_q <= 1'b0;
					cs_q <= 1'b0;
					pos_q <= 12'h000;
				end
				default: ;
			endcase
		end else if (rd_cap && dop_q == OP_DATA) begin
			pos_q <= pos_q + 12'h001;
		end
	end

	// sequencer next state
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		cnt_d = cnt_q;
		unique case (st_q)
			ST_IDLE: if (go) begin
				ph_d = 1'b0;
				cnt_d = 7'h00;
				st_d = (op_w == OP_DATA) ? ST_READ : ST_CMD1;
				if (op_w == OP_DATA) begin
					cnt_d = nb12[6:0];
				end
			end
			ST_CMD1: begin
				ph_d = ~ph_q;
				if (ph_q) begin
					if (dop_q == OP_STAT) begin
						st_d = ST_READ;
						cnt_d = 7'h01;
					end else if (desc_q.naddr != 3'h0) begin
						st_d = ST_ADDR;
					end else begin
						st_d = desc_q.wait_rb ? ST_TWB : ST_IDLE;
					end
				end
			end
			ST_ADDR: begin
				ph_d = ~ph_q;
				if (ph_q) begin
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == {4'h0, desc_q.naddr} - 7'h01) begin
						st_d = ST_CMD2;
						cnt_d = 7'h00;
					end
				end
			end
			ST_CMD2: begin
				ph_d = ~ph_q;
				if (ph_q) begin
					st_d = desc_q.wait_rb ? ST_TWB : ST_IDLE;
				end
			end
			ST_TWB: begin
				cnt_d = cnt_q + 7'h01;
				if (cnt_q == 7'(`NFC_WB_CYC - 1)) begin
					st_d = ST_BUSY;
				end
			end
			ST_BUSY: if (ready_busy_n) begin
				st_d = ST_IDLE;
			end
			ST_READ: begin
				ph_d = ~ph_q;
				if (ph_q) begin
					cnt_d = cnt_q - 7'h01;
					if (cnt_q == 7'h01) begin
						st_d = (dop_q == OP_STAT && desc_q.has_c2)
							? ST_CMD2 : ST_IDLE;
					end
				end
			end
			// unused state code falls back to idle
			default: st_d = ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_IDLE;
			ph_q <= 1'b0;
			cnt_q <= 7'h00;
			dop_q <= OP_PAGE;
			desc_q <= '0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			if (go) begin
				dop_q <= op_w;
				desc_q <= dsel;
			end
		end
	end

	// pin levels for the coming cycle
	always_comb begin
		pins_d = '{ce_n: (st_d == ST_IDLE), cle: 1'b0, ale: 1'b0,
			we_n: 1'b1, re_n: 1'b1, wp_n: wp_n_q, io_o: 8'h00,
			io_oe: 1'b0};
		unique case (st_d)
			ST_CMD1, ST_CMD2: begin
				pins_d.cle = 1'b1;
				pins_d.we_n = ph_d;
				pins_d.io_o = (st_d == ST_CMD1) ? dsel.c1 : dsel.c2;
				pins_d.io_oe = 1'b1;
			end
			ST_ADDR: begin
				pins_d.ale = 1'b1;
				pins_d.we_n = ph_d;
				pins_d.io_o = abyte(cnt_d, col_q, row_q);
				pins_d.io_oe = 1'b1;
			end
			ST_READ: pins_d.re_n = ph_d;
			default: ;
		endcase
	end

	// pins come straight from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
				re_n: 1'b1, wp_n: 1'b0, io_o: 8'h00, io_oe: 1'b0};
		end else begin
			pins <= pins_d;
		end
	end

	// read byte captured at the end of each read strobe low
	assign rd_cap = (st_q == ST_READ) & ~ph_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= 8'h00;
			wp_q <= '0;
			fill_q <= 7'h00;
		end else if (go && op_w == OP_DATA) begin
			wp_q <= '0;
			fill_q <= 7'h00;
		end else if (rd_cap && dop_q == OP_STAT) begin
			stat_q <= nand_io_i;
		end else if (rd_cap) begin
			wp_q <= wp_q + 1'b1;
			fill_q <= fill_q + 7'h01;
		end
	end

	// buffer read pointer, advanced by each data register read below the fill count
	always_comb begin
		rp_d = rp_q;
		if (go && op_w == OP_DATA) begin
			rp_d = '0;
		end else if (data_rd && {1'b0, rp_q} < fill_q) begin
			rp_d = rp_q + 1'b1;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rp_q <= '0;
		end else begin
			rp_q <= rp_d;
		end
	end

	nfc_buf u_buf (
		.clk   (hclk),
		.we    (rd_cap && dop_q == OP_DATA),
		.waddr (wp_q),
		.wdata (nand_io_i),
		.raddr (rp_d),
		.rdata (buf_q)
	);

	// register read mux
	always_comb begin
		unique case (haddr[7:0])
			`NFC_A_CTRL: rmux = {17'h0, len_q, 5'h00, op_q};
			`NFC_A_COL:  rmux = {20'h0, col_q};
			`NFC_A_ROW:  rmux = {16'h0, row_q};
			`NFC_A_STAT: rmux = {9'h0, fill_q, stat_q, 3'h0, cs_q, pg_q,
				err_q, ready_busy_n, (st_q != ST_IDLE)};
			`NFC_A_DATA: rmux = {24'h0, buf_q};
			`NFC_A_CFG:  rmux = {31'h0, wp_n_q};
			default:     rmux = 32'h0;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (ap_ok && !hwrite) begin
			hrdata <= rmux;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence page_cfm_s;
		st_q == ST_CMD2 && dop_q == OP_PAGE && pins.io_o == `NFC_C_PAGE;
	endsequence
	sequence busy_wait_s;
		st_q == ST_TWB [*2] ##1 st_q == ST_BUSY;
	endsequence

	col_first_a: assert property (
		st_q == ST_ADDR && cnt_q == 7'h00 |-> pins.io_o == col_q[7:0]
	) else $error("first address byte not column low");
	row_last_a: assert property (
		st_q == ST_ADDR && cnt_q == 7'h03 |-> pins.io_o == row_q[15:8]
	) else $error("fourth address byte not row high");
	nib_low_a: assert property (
		st_q == ST_ADDR && cnt_q == 7'h01 |-> pins.io_o[7:4] == 4'h0
	) else $error("second address byte upper nibble not low");
	op_legal_a: assert property (
		pins.cle && !pins.we_n |-> pins.io_o inside {`NFC_C_READ,
		`NFC_C_PAGE, `NFC_C_CACHE, `NFC_C_LAST, `NFC_C_STATUS,
		`NFC_C_RESET, `NFC_C_COL, `NFC_C_COLGO}
	) else $error("undefined opcode driven");
	page_seq_a: assert property (
		page_cfm_s ##0 ph_q |=> busy_wait_s
	) else $error("page read confirm not followed by busy wait");
	reissue_a: assert property (
		st_q == ST_READ && dop_q == OP_STAT && ph_q && desc_q.has_c2
		|=> pins.cle && pins.io_o == `NFC_C_READ
	) else $error("read opcode not reissued after status");
	col_zero_a: assert property (
		go && (op_w == OP_SEQC || op_w == OP_RANDC) |=> pos_q == 12'h000
	) else $error("cache output column not reset");
	re_step_a: assert property (
		rd_cap && dop_q == OP_DATA |=> pos_q == $past(pos_q) + 12'h001
	) else $error("column pointer not advanced per strobe");
	rb_gate_a: assert property (
		go && !ready_busy_n |=> pins.io_o inside {`NFC_C_STATUS,
		`NFC_C_RESET}
	) else $error("command other than status or reset while busy");
	read_mode_a: assert property (
		!pins.re_n |-> !pins.cle && !pins.ale && !pins.ce_n && pins.we_n
		##1 pins.re_n
	) else $error("read strobe outside data output mode");
endmodule

/* File: dv/nfc_nand_model.sv */
// behavioural nand device answering page and cache reads
`timescale 1ns/1ns
module nfc_nand_model #(
	parameter int T_LOAD = 2000, // page_load_time in ns
	parameter int T_CBSY = 1000  // cache_busy_time in ns
) (
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] io_in,
	output logic      [7:0] io_out,
	output logic            rb_n,
	output logic            viol
);
	logic [11:0] col_q;   // assembled column
	logic [15:0] row_q;   // assembled row
	logic [15:0] drow_q;  // page held in data register
	logic [15:0] crow_q;  // page held in cache register
	logic [11:0] ptr_q;   // output column
	logic [7:0]  dout;    // byte on the bus
	logic [2:0]  acnt;    // address cycles since command
	logic        stat_q;  // status output mode
	logic        cache_q; // cache session open
	logic [7:0]  last_c;  // previous command
	int          bt;      // busy length of current job
	event        go;
	// page content, a simple mix of row and column
	function automatic logic [7:0] pb(input logic [15:0] r,
		input logic [11:0] c);
		return (r[7:0] ^ c[7:0]) + {4'h0, c[11:8]};
	endfunction
	// power-up state: read mode, ready
	initial begin
		{col_q, row_q, drow_q, crow_q, ptr_q, dout} = '0;
		{acnt, cache_q, last_c, viol, bt} = '0;
		rb_n = 1'b1;
		stat_q = 1'b0;
	end
	// released bus shows the inverse of the last byte
	assign io_out = (!ce_n && !re_n) ? dout : ~dout;
	// command and address latch on the write strobe rise
	always @(posedge we_n) begin
		if (!ce_n && cle && !ale) begin
			if (!rb_n && io_in != 8'h70 && io_in != 8'hff) viol = 1'b1;
			case (io_in)
			8'h00: begin acnt = 3'd0; stat_q = 1'b0; end
			8'h05: acnt = 3'd0;
			8'h30: begin
				{drow_q, crow_q, ptr_q} = {row_q, row_q, col_q};
				cache_q = 1'b0;
				bt = T_LOAD;
				-> go;
			end
			8'h31: begin
				crow_q = drow_q;
				if (last_c == 8'h00 && acnt == 3'd4) drow_q = row_q;
				else drow_q = drow_q + 16'h1;
				{ptr_q, cache_q, bt} = {12'h0, 1'b1, T_CBSY};
				-> go;
			end
			8'h3f: begin
				crow_q = drow_q;
				{ptr_q, cache_q, bt} = {12'h0, 1'b0, T_CBSY};
				-> go;
			end
			8'he0: begin
				ptr_q = col_q;
				if (col_q >= 12'h840) viol = 1'b1;
			end
			8'h70: stat_q = 1'b1;
			8'hff: begin {stat_q, cache_q, ptr_q, bt} = '0; bt = 100; -> go; end
			// program, erase, id and feature commands leave the array as it is
			8'h35, 8'h80, 8'h85, 8'h10, 8'h15, 8'h60, 8'hd0, 8'h90,
			8'hec, 8'hed, 8'hee, 8'hef, 8'ha5, 8'ha0, 8'haf: ;
			default: viol = 1'b1;
			endcase
			last_c = io_in;
		end else if (!ce_n && ale && !cle) begin
			case (acnt)
			3'd0: col_q[7:0] = io_in;
			3'd1: begin
				col_q[11:8] = io_in[3:0];
				if (io_in[7:4] != 4'h0) viol = 1'b1;
			end
			3'd2: row_q[7:0] = io_in;
			3'd3: row_q[15:8] = io_in;
			default: ;
			endcase
			if (acnt != 3'd4) acnt = acnt + 3'd1;
		end
	end
	// busy pulse for each array or cache transfer and for reset
	always begin
		@(go);
		rb_n = 1'b0;
		#(bt);
		rb_n = 1'b1;
	end
	// output on the read strobe fall, column advances
	always @(negedge re_n) begin
		if (!ce_n && !cle && !ale && we_n) begin
			if (stat_q) dout = {wp_n, rb_n, rb_n & ~cache_q, 5'h0};
			else if (ptr_q < 12'h840) begin
				dout = pb(crow_q, ptr_q);
				ptr_q = ptr_q + 12'h1;
			end
		end
	end
endmodule

/* File: dv/tb_nand_page_and_cache_read.sv */
// self-checking bench for the nand read controller
`timescale 1ns/1ns
`include "nfc_params.svh"
module tb_nand_page_and_cache_read
	import nfc_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [7:0]  nand_io_i;
	logic        ready_busy_n, viol, saw_busy;
	nfc_pins_s   pins;
	int          mismatches, n_checks, cyc;
	assign hready = hreadyout;
	nfc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .nand_io_i(nand_io_i),
		.ready_busy_n(ready_busy_n), .pins(pins));
	nfc_nand_model model_u (.ce_n(pins.ce_n), .cle(pins.cle),
		.ale(pins.ale), .we_n(pins.we_n), .re_n(pins.re_n),
		.wp_n(pins.wp_n), .io_in(pins.io_o), .io_out(nand_io_i),
		.rb_n(ready_busy_n), .viol(viol));
	// expected page byte
	function automatic logic [7:0] eb(input logic [15:0] r,
		input logic [11:0] c);
		return (r[7:0] ^ c[7:0]) + {4'h0, c[11:8]};
	endfunction
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single ahb transfer, read data left in rd
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic go(input logic [2:0] op, input logic [6:0] n);
		xfer(1'b1, `NFC_A_CTRL, {17'h0, n, 5'h0, op});
		repeat (2) @(posedge hclk);
	endtask
	// poll status until the sequencer is idle
	task automatic wait_idle();
		do begin
			xfer(1'b0, `NFC_A_STAT, 32'h0);
			if (rd[1] === 1'b0) saw_busy = 1'b1;
		end while (rd[0] !== 1'b0);
	endtask
	task automatic run(input logic [2:0] op, input logic [6:0] n);
		go(op, n);
		wait_idle();
	endtask
	// pop n buffer bytes and compare with the page
	task automatic pull(input logic [15:0] r, input logic [11:0] c,
		input int n);
		for (int i = 0; i < n; i++) begin
			xfer(1'b0, `NFC_A_DATA, 32'h0);
			check("data", {24'h0, rd[7:0]}, {24'h0, eb(r, c + 12'(i))});
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{mismatches, n_checks, cyc, saw_busy} = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset state and refusals
		check("pins", {17'h0, pins}, 32'h4c00);
		check("hresp", {31'h0, hresp}, 32'h0);
		xfer(1'b0, `NFC_A_STAT, 32'h0);
		check("stat", rd & 32'h1f, 32'h2);
		run(OP_DATA, 7'h4);
		check("err", {31'h0, rd[2]}, 32'h1);
		xfer(1'b1, `NFC_A_STAT, 32'h4);
		xfer(1'b1, `NFC_A_CFG, 32'h1);
		xfer(1'b0, 8'h18, 32'h0);
		check("unmapped", rd, 32'h0);
		check("wp", {31'h0, pins.wp_n}, 32'h1);
		$display("test reset done");
		// page read near page end, second order while busy
		xfer(1'b1, `NFC_A_COL, 32'h83c);
		xfer(1'b1, `NFC_A_ROW, 32'h1234);
		go(OP_PAGE, 7'h0);
		go(OP_DATA, 7'h1);
		wait_idle();
		check("busy seen", {31'h0, saw_busy}, 32'h1);
		check("busy refusal", {31'h0, rd[2]}, 32'h1);
		check("loaded", {27'h0, rd[4:0]}, 32'h1e);
		check("col", {20'h0, model_u.col_q}, 32'h83c);
		check("row", {16'h0, model_u.row_q}, 32'h1234);
		xfer(1'b1, `NFC_A_STAT, 32'h4);
		run(OP_DATA, 7'h8);
		check("clip", {25'h0, rd[22:16]}, 32'h4);
		pull(16'h1234, 12'h83c, 4);
		$display("test page read done");
		// column change then status poll
		xfer(1'b1, `NFC_A_COL, 32'h5);
		run(OP_COL, 7'h0);
		run(OP_DATA, 7'h3);
		pull(16'h1234, 12'h005, 3);
		run(OP_STAT, 7'h0);
		check("status", {24'h0, rd[15:8]}, 32'he0);
		run(OP_DATA, 7'h2);
		pull(16'h1234, 12'h008, 2);
		// column beyond the page end must be refused
		xfer(1'b1, `NFC_A_COL, 32'h840);
		run(OP_COL, 7'h0);
		check("col range", {31'h0, rd[2]}, 32'h1);
		xfer(1'b1, `NFC_A_STAT, 32'h4);
		$display("test column and status done");
		// cache session: sequential, random, last
		run(OP_SEQC, 7'h0);
		check("session", {31'h0, rd[4]}, 32'h1);
		run(OP_STAT, 7'h0);
		check("cache status", {24'h0, rd[15:8]}, 32'hc0);
		run(OP_DATA, 7'h2);
		pull(16'h1234, 12'h000, 2);
		run(OP_SEQC, 7'h0);
		run(OP_DATA, 7'h2);
		pull(16'h1235, 12'h000, 2);
		xfer(1'b1, `NFC_A_ROW, 32'h200);
		run(OP_RANDC, 7'h0);
		check("rand page", {16'h0, model_u.drow_q}, 32'h200);
		run(OP_DATA, 7'h2);
		pull(16'h1236, 12'h000, 2);
		run(OP_LASTC, 7'h0);
		run(OP_DATA, 7'h1);
		pull(16'h0200, 12'h000, 1);
		run(OP_STAT, 7'h0);
		check("last status", {24'h0, rd[15:8]}, 32'he0);
		$display("test cache read done");
		// device reset drops the page
		run(OP_RST, 7'h0);
		check("no page", {31'h0, rd[3]}, 32'h0);
		run(OP_SEQC, 7'h0);
		check("no session", {31'h0, rd[2]}, 32'h1);
		check("model", {31'h0, viol}, 32'h0);
		$display("test reset op done");
		results();
	end
endmodule
